// >>> hdl/pbc_path_ctrl.sv
// Charge sequencing, derating, boost and port path control of a power bank.
// Assumes all inputs are comparator or detector flags synchronous to clk_i.
// What this block does
// - Trickle below 3V, fast current once battery reaches 3V.
// - At target voltage hold voltage; stop when current reaches termination level.
// - After completion restart charging when battery drops below recharge threshold.
// - Target voltage decoded from key pin pull-up: 4.2, 4.35, 4.4, 4.5V.
// - Input current limit 2A on legacy ports, 3A on the Type-C port.
// - Below 5C half current, below 0C stop, above 10C normal.
// - Above 45C target minus 0.1V, above 50C stop, below 40C normal.
// - Temperature derating can be disabled entirely.
// - Die regulation reduces current; die shutdown stops charging, powers device off.
// - Phase timeout terminates charge until the adapter is reinserted.
// - Trickle timeout is 40 minutes.
// - Fast charge timeout is 33 hours.
// - Boost pulse-skips at light load, fixed frequency at heavy load.
// - Boost off outside -20C..60C; restarts only on key or load event.
// - Die regulation lowers output; die shutdown stops boost until reset.
// - Input undervoltage, overvoltage, overload and short stop the boost.
// - Key or load insert enables Type-A; light load disables A and C.
// - Type-C source attach turns path and charger on; detach turns charger off.
// - Type-C sink attach enables port and boost; detach or light load disables.
// - Legacy adapter insertion enables that path and starts charging.
// - Pass-through suppresses light load detect; can be disabled; A and C together.
// - Small current mode: no light-load shutdown two hours, exits on double key.
// - Try-source role; advertise 3A with sink and boost, or adapter without boost.
// - Phone detection drives data lines to 2.7V or 1.2V.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "pbc_defines.svh"

module pbc_path_ctrl
    import pbc_pkg::*;
#(
    parameter logic [43:0] TRICKLE_CYC = 44'(`PBC_TRICKLE_TIMEOUT_CYC),
    parameter logic [43:0] FAST_CYC    = 44'(`PBC_FAST_TIMEOUT_CYC),
    parameter logic [39:0] SMALL_CYC   = 40'(`PBC_SMALL_MODE_CYC),
    parameter logic [31:0] LL_CYC      = 32'(`PBC_LIGHT_LOAD_CYC)
) (
    input  wire logic        clk_i,                         // System clock
    input  wire logic        reset_i,                       // Sync reset, high
    input  wire logic [7:0]  addr_i,                        // Register address
    input  wire logic [31:0] wdata_i,                       // Write data
    input  wire logic        wr_i,                          // Write strobe
    input  wire logic        rd_i,                          // Read strobe
    output logic      [31:0] rdata_o,                       // Read data, next cycle
    input  wire logic        batt_below_3v_i,               // Battery under 3V
    input  wire logic        batt_at_target_i,              // Battery at target
    input  wire logic        chg_below_term_i,              // Current at termination
    input  wire logic        batt_below_recharge_i,         // Under recharge level
    input  wire logic        temp_below_0_i,                // Battery under 0C
    input  wire logic        temp_below_5_i,                // Battery under 5C
    input  wire logic        temp_above_10_i,               // Battery over 10C
    input  wire logic        temp_above_40_i,               // Battery over 40C
    input  wire logic        temp_above_45_i,               // Battery over 45C
    input  wire logic        temp_above_50_i,               // Battery over 50C
    input  wire logic        temp_above_60_i,               // Battery over 60C
    input  wire logic        temp_below_m20_i,              // Battery under -20C
    input  wire logic        die_regulate_i,                // Die at regulation
    input  wire logic        die_shutdown_i,                // Die at shutdown
    input  wire logic [1:0]  key_vtarget_strap_pin_i,       // Decoded pull-up code
    input  wire logic        indicator2_data_strap_pin_i,   // 100K pull-down seen
    input  wire logic        micro_adapter_i,               // Legacy adapter in
    input  wire logic        typec_source_i,                // Type-C source attached
    input  wire logic        typec_sink_i,                  // Type-C sink attached
    input  wire logic        short_key_i,                   // Short key, pulse
    input  wire logic        double_key_i,                  // Double short key, pulse
    input  wire logic        load_insert_i,                 // Load insert, pulse
    input  wire logic        light_load_i,                  // Output under ~60mA
    input  wire logic        heavy_load_i,                  // Output at heavy load
    input  wire logic        bst_in_uv_i,                   // Boost input undervoltage
    input  wire logic        bst_out_ov_i,                  // Boost output overvoltage
    input  wire logic        bst_overload_i,                // Boost output overload
    input  wire logic        bst_short_i,                   // Boost output short
    input  wire logic [1:0]  phone_type_i,                  // 0 none, 1 2.4A, 2 2A
    output logic             chg_enable_o,                  // Charger running
    output logic             chg_fast_current_o,            // Fast current, else trickle
    output logic             chg_half_current_o,            // Cold half current
    output logic             chg_thermal_reduce_o,          // Die regulation cut
    output logic             chg_ilim_3a_o,                 // 3A input, else 2A
    output logic [1:0]       vtarget_code_o,                // Target voltage code
    output logic             vtarget_drop_o,                // Target minus 0.1V
    output logic             micro_path_o,                  // Legacy input path on
    output logic             typec_path_o,                  // Type-C path on
    output logic             port_a_on_o,                   // Type-A output on
    output logic             boost_on_o,                    // Boost running
    output logic             pulse_skip_operation_o,        // Pulse skip, else PWM
    output logic             bst_vout_reduce_o,             // Boost output lowered
    output logic             small_mode_o,                  // Small current mode
    output logic             adv_3a_o,                      // Advertise 3A as source
    output logic             try_src_o,                     // Try-source role enabled
    output logic [1:0]       dpdm_level_o,                  // Data line level code
    output logic             power_off_o                    // Whole device off
);

    typedef struct packed {
        pbc_chg_state_t chg_state;
        logic [43:0]    phase_cnt;
        logic           strap_done;
        logic [1:0]     vtarget;
        logic           cold_half;
        logic           cold_stop;
        logic           hot_drop;
        logic           hot_stop;
        logic           power_off;
        logic           port_a;
        logic           port_c;
        logic           sink_q;
        logic           small_mode;
        logic [39:0]    small_cnt;
        logic [31:0]    ll_cnt;
        logic [3:0]     ctrl;
        logic           therm;
        logic           src3a;
        logic           micro;
        logic           adv3a;
        logic [1:0]     dpdm;
        logic [31:0]    rdata;
    } pbc_state_t;

    pbc_state_t r;
    pbc_state_t next_r;

    logic src_present;
    logic derate_on;
    logic pass_dis;
    logic boost_on;
    logic chg_active;
    logic chg_allowed;
    logic bst_fault;
    logic ll_suppress;
    logic ll_expire;
    logic small_enter;

    function automatic logic is_charging(input pbc_chg_state_t s);
        return (s == PBC_TRICKLE) || (s == PBC_FAST) || (s == PBC_HOLD_V);
    endfunction

    always_comb begin
        src_present = typec_source_i | micro_adapter_i;
        derate_on   = ~r.ctrl[`PBC_CTRL_DERATE_DIS];
        pass_dis    = r.ctrl[`PBC_CTRL_PASS_DIS];
        boost_on    = r.port_a | r.port_c;
        chg_active  = is_charging(r.chg_state);
        // Pass-through off: charger yields while the boost supplies a load
        chg_allowed = src_present & ~r.power_off
                    & ~(derate_on & (r.cold_stop | r.hot_stop))
                    & ~(pass_dis & boost_on);
        bst_fault   = temp_above_60_i | temp_below_m20_i
                    | die_shutdown_i | r.power_off
                    | bst_in_uv_i | bst_out_ov_i | bst_overload_i | bst_short_i;
        ll_suppress = r.small_mode | (chg_active & ~pass_dis);
        ll_expire   = (r.ll_cnt >= LL_CYC - 32'h1);
        small_enter = r.ctrl[`PBC_CTRL_SERIAL_MODE]
                    ? (wr_i && addr_i == `PBC_ADDR_CTRL && wdata_i[`PBC_CTRL_SMALL_ENTER])
                    : (~r.strap_done & indicator2_data_strap_pin_i);

        next_r = r;
        next_r.phase_cnt = r.phase_cnt + 44'h1;

        // Straps are taken in the first cycle after reset release
        if (!r.strap_done) begin
            next_r.strap_done = 1'b1;
            next_r.vtarget    = key_vtarget_strap_pin_i;
        end

        // Temperature bands, each with its own hysteresis
        if (temp_below_5_i) next_r.cold_half = 1'b1;
        else if (temp_above_10_i) next_r.cold_half = 1'b0;
        if (temp_below_0_i) next_r.cold_stop = 1'b1;
        else if (!temp_below_5_i) next_r.cold_stop = 1'b0;
        if (temp_above_45_i) next_r.hot_drop = 1'b1;
        else if (!temp_above_40_i) next_r.hot_drop = 1'b0;
        if (temp_above_50_i) next_r.hot_stop = 1'b1;
        else if (!temp_above_45_i) next_r.hot_stop = 1'b0;

        // Only reset brings the device back after die shutdown
        if (die_shutdown_i) next_r.power_off = 1'b1;
        next_r.therm = die_regulate_i & chg_active;

        // Charge sequence; removing every source also clears a timeout
        if (!src_present) begin
            next_r.chg_state = PBC_IDLE;
            next_r.phase_cnt = 44'h0;
        end else begin
            case (r.chg_state)
                PBC_IDLE: begin
                    next_r.phase_cnt = 44'h0;
                    if (chg_allowed) begin
                        next_r.chg_state = batt_below_3v_i ? PBC_TRICKLE : PBC_FAST;
                    end
                end
                PBC_TRICKLE: begin
                    if (!chg_allowed) begin
                        next_r.chg_state = PBC_IDLE;
                    end else if (r.phase_cnt >= TRICKLE_CYC - 44'h1) begin
                        next_r.chg_state = PBC_TIMEOUT;
                    end else if (!batt_below_3v_i) begin
                        next_r.chg_state = PBC_FAST;
                        next_r.phase_cnt = 44'h0;
                    end
                end
                PBC_FAST: begin
                    if (!chg_allowed) begin
                        next_r.chg_state = PBC_IDLE;
                    end else if (r.phase_cnt >= FAST_CYC - 44'h1) begin
                        next_r.chg_state = PBC_TIMEOUT;
                    end else if (batt_at_target_i) begin
                        next_r.chg_state = PBC_HOLD_V;
                    end
                end
                PBC_HOLD_V: begin
                    if (!chg_allowed) next_r.chg_state = PBC_IDLE;
                    else if (chg_below_term_i) next_r.chg_state = PBC_DONE;
                end
                PBC_DONE: begin
                    if (batt_below_recharge_i) next_r.chg_state = PBC_IDLE;
                end
                PBC_TIMEOUT: begin
                    next_r.chg_state = PBC_TIMEOUT;
                end
                default: begin
                    next_r.chg_state = PBC_IDLE;
                end
            endcase
        end

        // Output ports; a fault blocks any start event in the same cycle
        next_r.sink_q = typec_sink_i;
        if (bst_fault || ll_expire) begin
            next_r.port_a = 1'b0;
        end else if (short_key_i || load_insert_i) begin
            next_r.port_a = 1'b1;
        end
        if (bst_fault || ll_expire || !typec_sink_i) begin
            next_r.port_c = 1'b0;
        end else if ((typec_sink_i && !r.sink_q) || short_key_i) begin
            next_r.port_c = 1'b1;
        end

        // Light load must persist for the full window before ports drop
        if (boost_on && light_load_i && !ll_suppress && !ll_expire) begin
            next_r.ll_cnt = r.ll_cnt + 32'h1;
        end else begin
            next_r.ll_cnt = 32'h0;
        end

        // Entry wins over a double key in the same cycle
        if (small_enter) begin
            next_r.small_mode = 1'b1;
            next_r.small_cnt  = 40'h0;
        end else if (r.small_mode) begin
            next_r.small_cnt = r.small_cnt + 40'h1;
            if (double_key_i || r.small_cnt >= SMALL_CYC - 40'h1) begin
                next_r.small_mode = 1'b0;
            end
        end

        next_r.src3a = typec_source_i;
        next_r.micro = micro_adapter_i;
        next_r.adv3a = (typec_sink_i & boost_on) | (micro_adapter_i & ~boost_on);
        case (phone_type_i)
            2'h1:    next_r.dpdm = `PBC_DPDM_2V7;
            2'h2:    next_r.dpdm = `PBC_DPDM_1V2;
            default: next_r.dpdm = `PBC_DPDM_NONE;
        endcase

        // Register port; the enter bit is a command and never stored
        if (wr_i && addr_i == `PBC_ADDR_CTRL) begin
            next_r.ctrl = {1'b0, wdata_i[2:0]};
        end
        next_r.rdata = 32'h0;
        if (rd_i) begin
            case (addr_i)
                `PBC_ADDR_CTRL:   next_r.rdata = {28'h0, r.ctrl};
                `PBC_ADDR_STATUS: next_r.rdata = {20'h0, r.adv3a, r.vtarget, r.power_off,
                                                  r.small_mode, r.port_c, r.port_a,
                                                  boost_on, 1'b0, r.chg_state};
                default:          next_r.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            r           <= '0;
            r.chg_state <= PBC_IDLE;
            r.ctrl      <= `PBC_CTRL_RESET;
            r.vtarget   <= `PBC_VT_4V20;
        end else begin
            r <= next_r;
        end
    end

    assign rdata_o                = r.rdata;
    assign chg_enable_o           = chg_active;
    assign chg_fast_current_o     = (r.chg_state == PBC_FAST) || (r.chg_state == PBC_HOLD_V);
    assign chg_half_current_o     = r.cold_half & derate_on;
    assign chg_thermal_reduce_o   = r.therm;
    assign chg_ilim_3a_o          = r.src3a;
    assign vtarget_code_o         = r.vtarget;
    assign vtarget_drop_o         = r.hot_drop & derate_on;
    assign micro_path_o           = r.micro;
    assign typec_path_o           = r.src3a | r.port_c;
    assign port_a_on_o            = r.port_a;
    assign boost_on_o             = boost_on;
    assign pulse_skip_operation_o = boost_on & ~heavy_load_i;
    assign bst_vout_reduce_o      = boost_on & die_regulate_i;
    assign small_mode_o           = r.small_mode;
    assign adv_3a_o               = r.adv3a;
    assign try_src_o              = ~reset_i;
    assign dpdm_level_o           = r.dpdm;
    assign power_off_o            = r.power_off;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_TRICKLE_TO_FAST: assert property (
        r.chg_state == PBC_TRICKLE && chg_allowed && !batt_below_3v_i && src_present
        && r.phase_cnt < TRICKLE_CYC - 44'h1 |=> r.chg_state == PBC_FAST && r.phase_cnt == 44'h0)
        else $error("trickle did not move to fast at 3V");
    AST_HOLD_TO_DONE: assert property (
        r.chg_state == PBC_HOLD_V && chg_allowed && chg_below_term_i && src_present
        |=> r.chg_state == PBC_DONE ##0 !chg_enable_o)
        else $error("termination did not complete the cycle");
    AST_RECHARGE: assert property (
        r.chg_state == PBC_DONE && batt_below_recharge_i && src_present
        ##1 chg_allowed && src_present |=> chg_enable_o)
        else $error("no recharge after drop below threshold");
    AST_STRAP: assert property (
        $rose(r.strap_done) |-> vtarget_code_o == $past(key_vtarget_strap_pin_i)
        ##1 $stable(vtarget_code_o)[*3])
        else $error("target strap not captured or not held");
    AST_COLD_STOP: assert property (
        temp_below_0_i && derate_on ##1 temp_below_0_i && derate_on |=> !chg_enable_o)
        else $error("charging continued below 0C");
    AST_HOT_DROP: assert property (
        temp_above_45_i && derate_on |=> vtarget_drop_o)
        else $error("target not lowered above 45C");
    AST_DERATE_OFF: assert property (
        r.ctrl[`PBC_CTRL_DERATE_DIS] |-> !chg_half_current_o && !vtarget_drop_o)
        else $error("derating active while disabled");
    AST_DIE_SHUT: assert property (
        die_shutdown_i |=> power_off_o ##1 (!chg_enable_o && !boost_on_o)[*2])
        else $error("die shutdown did not power off");
    AST_TIMEOUT_HOLD: assert property (
        r.chg_state == PBC_TIMEOUT && src_present |=> r.chg_state == PBC_TIMEOUT)
        else $error("timeout left without adapter removal");
    AST_BOOST_FAULT: assert property (
        bst_fault |=> !port_a_on_o && !boost_on_o)
        else $error("boost still on after fault");
    AST_ADV3A: assert property (
        typec_sink_i && boost_on && !bst_fault |=> adv_3a_o)
        else $error("3A not advertised with sink and boost");
    AST_LEVEL: assert property (
        phone_type_i == 2'h2 |=> dpdm_level_o == `PBC_DPDM_1V2)
        else $error("wrong data line level");

    COV_DONE:     cover property (r.chg_state == PBC_HOLD_V ##1 r.chg_state == PBC_DONE);
    COV_TIMEOUT:  cover property (r.chg_state == PBC_TIMEOUT);
    COV_SMALL:    cover property ($fell(r.small_mode) && double_key_i);
    COV_BOTH_OUT: cover property (port_a_on_o && r.port_c && chg_enable_o);

endmodule

// >>> pkg/pbc_defines.svh
// Constants of the power bank path controller: offsets, fields, reset values, timings.
// Assumes a 100 MHz system clock; every count is derived from a printed time.
`ifndef PBC_DEFINES_SVH
`define PBC_DEFINES_SVH

`define PBC_CLK_HZ              64'd100000000
`define PBC_TRICKLE_TIMEOUT_MIN 64'd40
`define PBC_FAST_TIMEOUT_HOUR   64'd33
`define PBC_SMALL_MODE_HOUR     64'd2
`define PBC_LIGHT_LOAD_SEC      64'd32
`define PBC_TRICKLE_TIMEOUT_CYC (`PBC_TRICKLE_TIMEOUT_MIN * 64'd60 * `PBC_CLK_HZ)
`define PBC_FAST_TIMEOUT_CYC    (`PBC_FAST_TIMEOUT_HOUR * 64'd3600 * `PBC_CLK_HZ)
`define PBC_SMALL_MODE_CYC      (`PBC_SMALL_MODE_HOUR * 64'd3600 * `PBC_CLK_HZ)
`define PBC_LIGHT_LOAD_CYC      (`PBC_LIGHT_LOAD_SEC * `PBC_CLK_HZ)

`define PBC_ADDR_CTRL           8'h00
`define PBC_ADDR_STATUS         8'h04
`define PBC_CTRL_DERATE_DIS     0
`define PBC_CTRL_PASS_DIS       1
`define PBC_CTRL_SERIAL_MODE    2
`define PBC_CTRL_SMALL_ENTER    3
`define PBC_CTRL_RESET          4'h0

`define PBC_VT_4V20             2'h0
`define PBC_VT_4V35             2'h1
`define PBC_VT_4V40             2'h2
`define PBC_VT_4V50             2'h3
`define PBC_DPDM_NONE           2'h0
`define PBC_DPDM_2V7            2'h1
`define PBC_DPDM_1V2            2'h2

`endif

// >>> pkg/pbc_pkg.sv
// Types of the power bank path controller.
// Assumes pbc_defines.svh supplies the numeric constants.
package pbc_pkg;
    // Gray along idle, trickle, fast, voltage hold, done
    typedef enum logic [2:0] {
        PBC_IDLE    = 3'h0,
        PBC_TRICKLE = 3'h1,
        PBC_FAST    = 3'h3,
        PBC_HOLD_V  = 3'h2,
        PBC_DONE    = 3'h6,
        PBC_TIMEOUT = 3'h4
    } pbc_chg_state_t;
endpackage

// >>> verif/pbc_batt_model.sv
// Battery and charger stage model: voltage climbs while charging and tapers at target.
// Assumes the bench may freeze the voltage to hold the block in one phase.
`timescale 1ns/1ps
module pbc_batt_model (
    input  wire logic clk_i,            // System clock
    input  wire logic chg_enable_i,     // Charger running
    input  wire logic pause_i,          // Freeze battery voltage
    output logic      below_3v_o,       // Under 3V
    output logic      at_target_o,      // At target voltage
    output logic      below_term_o,     // Current at termination
    output logic      below_recharge_o  // Under recharge level
);
    logic [4:0] volt = 5'h00;
    logic [3:0] taper = 4'h0;
    always_ff @(posedge clk_i) begin
        if (!pause_i && chg_enable_i) begin
            volt <= volt + {4'h0, volt != 5'h14};
        end else if (!pause_i) begin
            volt <= volt - {4'h0, volt != 5'h00};
        end
        // Taper only after a while at target, so the hold phase lasts visibly
        taper <= (chg_enable_i && volt == 5'h14) ? taper + {3'h0, taper != 4'hf} : 4'h0;
    end
    assign below_3v_o       = volt < 5'h0a;
    assign at_target_o      = volt == 5'h14;
    assign below_term_o     = taper == 4'hf;
    assign below_recharge_o = volt < 5'h10;
endmodule

// >>> verif/power_bank_path_controller_bench.sv
// Self-checking bench of the power bank path controller.
// Assumes the battery model stands on the charger side; short timer parameters.
`timescale 1ns/1ps
module power_bank_path_controller_bench;
    logic clk_i = 1'b0, reset_i = 1'b1, wr_i, rd_i, batt_below_3v_i, batt_at_target_i;
    logic chg_below_term_i;
    logic batt_below_recharge_i, temp_below_0_i, temp_below_5_i, temp_above_10_i, pause;
    logic temp_above_40_i, temp_above_45_i, temp_above_50_i, temp_above_60_i, temp_below_m20_i;
    logic die_regulate_i, die_shutdown_i, indicator2_data_strap_pin_i, micro_adapter_i;
    logic typec_source_i, typec_sink_i, short_key_i, double_key_i, load_insert_i, light_load_i;
    logic heavy_load_i, bst_in_uv_i, bst_out_ov_i, bst_overload_i, bst_short_i, chg_enable_o;
    logic chg_fast_current_o, chg_half_current_o, chg_thermal_reduce_o, chg_ilim_3a_o;
    logic vtarget_drop_o, micro_path_o, typec_path_o, port_a_on_o, boost_on_o, try_src_o;
    logic pulse_skip_operation_o, bst_vout_reduce_o, small_mode_o, adv_3a_o, power_off_o;
    logic [1:0] key_vtarget_strap_pin_i, phone_type_i, vtarget_code_o, dpdm_level_o;
    logic [7:0] addr_i;
    logic [31:0] wdata_i, rdata_o, d;
    int n_mismatch = 0, n_compared = 0;
    pbc_path_ctrl #(.TRICKLE_CYC(44'd20), .FAST_CYC(44'd400), .SMALL_CYC(40'd30),
        .LL_CYC(32'd8)) dut_u (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .batt_below_3v_i, .batt_at_target_i, .chg_below_term_i, .batt_below_recharge_i,
        .temp_below_0_i, .temp_below_5_i, .temp_above_10_i, .temp_above_40_i, .temp_above_45_i,
        .temp_above_50_i, .temp_above_60_i, .temp_below_m20_i, .die_regulate_i, .die_shutdown_i,
        .key_vtarget_strap_pin_i, .indicator2_data_strap_pin_i, .micro_adapter_i, .typec_sink_i,
        .typec_source_i, .short_key_i, .double_key_i, .load_insert_i, .light_load_i, .heavy_load_i,
        .bst_in_uv_i, .bst_out_ov_i, .bst_overload_i, .bst_short_i, .phone_type_i, .chg_enable_o,
        .chg_fast_current_o, .chg_half_current_o, .chg_thermal_reduce_o, .chg_ilim_3a_o, .adv_3a_o,
        .vtarget_code_o, .vtarget_drop_o, .micro_path_o, .typec_path_o, .port_a_on_o, .boost_on_o,
        .pulse_skip_operation_o, .bst_vout_reduce_o, .small_mode_o, .try_src_o, .dpdm_level_o,
        .power_off_o);
    pbc_batt_model batt_u (.clk_i, .chg_enable_i(chg_enable_o), .pause_i(pause),
        .below_3v_o(batt_below_3v_i), .at_target_o(batt_at_target_i),
        .below_term_o(chg_below_term_i), .below_recharge_o(batt_below_recharge_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        {rd_i, addr_i} <= {1'b1, a};
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (9000) @(posedge clk_i);
        n_mismatch++;
        test_done;
    end
    initial begin
        {wr_i, rd_i, addr_i, wdata_i, temp_below_0_i, temp_below_5_i, temp_above_10_i,
         temp_above_40_i, temp_above_45_i, temp_above_50_i, temp_above_60_i, temp_below_m20_i,
         die_regulate_i, die_shutdown_i, key_vtarget_strap_pin_i, indicator2_data_strap_pin_i,
         micro_adapter_i, typec_source_i, typec_sink_i, short_key_i, double_key_i, load_insert_i,
         light_load_i, heavy_load_i, bst_in_uv_i, bst_out_ov_i, bst_overload_i, bst_short_i,
         phone_type_i, pause} = '0;
        for (int s = 3; s >= 0; s--) begin
            @(posedge clk_i) {reset_i, key_vtarget_strap_pin_i} <= {1'b1, 2'(s)};
            repeat (6) @(posedge clk_i);
            reset_i <= 1'b0;
            wt(2);
            chk(vtarget_code_o, s);
        end
        @(posedge clk_i) typec_source_i <= 1'b1;
        wt(3);
        chk({chg_enable_o, chg_fast_current_o, chg_ilim_3a_o}, 3'h5);
        for (int i = 0; i < 99 && chg_fast_current_o !== 1'b1; i++) wt(1);
        rd(8'h04);
        chk(d[2:0], 3'h3);
        for (int i = 0; i < 99 && chg_enable_o !== 1'b0; i++) wt(1);
        rd(8'h04);
        chk(d[2:0], 3'h6);
        for (int i = 0; i < 99 && chg_enable_o !== 1'b1; i++) wt(1);
        chk({chg_enable_o, chg_fast_current_o}, 2'h3);
        rd(8'h08);
        chk(d, 32'h0);
        @(posedge clk_i) {pause, temp_below_5_i} <= 2'h3;
        wt(3);
        chk(chg_half_current_o, 1);
        @(posedge clk_i) temp_below_0_i <= 1'b1;
        wt(3);
        chk(chg_enable_o, 0);
        @(posedge clk_i) {temp_below_0_i, temp_below_5_i} <= 2'h0;
        wt(4);
        chk({chg_enable_o, chg_half_current_o}, 2'h3);
        @(posedge clk_i) {temp_above_10_i, temp_above_40_i, temp_above_45_i} <= 3'h7;
        wt(3);
        chk({chg_half_current_o, vtarget_drop_o}, 2'h1);
        @(posedge clk_i) temp_above_50_i <= 1'b1;
        wt(3);
        chk(chg_enable_o, 0);
        @(posedge clk_i) {temp_above_50_i, temp_above_45_i} <= 2'h0;
        wt(4);
        chk({chg_enable_o, vtarget_drop_o}, 2'h3);
        @(posedge clk_i) {wr_i, addr_i, wdata_i, temp_above_40_i} <= {9'h100, 32'h1, 1'b1};
        @(posedge clk_i) {wr_i, temp_below_5_i} <= 2'h1;
        wt(3);
        chk({vtarget_drop_o, chg_half_current_o}, 2'h0);
        @(posedge clk_i) {typec_source_i, pause} <= 2'h0;
        wt(30);
        chk(chg_enable_o, 0);
        @(posedge clk_i) {typec_source_i, pause} <= 2'h3;
        wt(14);
        chk(chg_enable_o, 1);
        wt(16);
        rd(8'h04);
        chk({chg_enable_o, d[2:0]}, 4'h4);
        @(posedge clk_i) typec_source_i <= 1'b0;
        @(posedge clk_i) typec_source_i <= 1'b1;
        wt(3);
        chk(chg_enable_o, 1);
        @(posedge clk_i) {typec_source_i, short_key_i} <= 2'h1;
        @(posedge clk_i) short_key_i <= 1'b0;
        #1 chk({port_a_on_o, boost_on_o, pulse_skip_operation_o}, 3'h7);
        @(posedge clk_i) heavy_load_i <= 1'b1;
        wt(1);
        chk(pulse_skip_operation_o, 0);
        @(posedge clk_i) bst_short_i <= 1'b1;
        @(posedge clk_i) bst_short_i <= 1'b0;
        wt(3);
        chk(boost_on_o, 0);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i) load_insert_i <= 1'b1;
            @(posedge clk_i) load_insert_i <= 1'b0;
            #1 chk(port_a_on_o, 1);
            @(posedge clk_i) {temp_above_60_i, light_load_i} <= (k == 2) ? 2'h1 : 2'h2;
            wt(12);
            chk(boost_on_o, 0);
            @(posedge clk_i) {temp_above_60_i, light_load_i} <= 2'h0;
        end
        @(posedge clk_i) typec_sink_i <= 1'b1;
        wt(2);
        chk({typec_path_o, boost_on_o, adv_3a_o}, 3'h7);
        @(posedge clk_i) typec_sink_i <= 1'b0;
        wt(2);
        chk({typec_path_o, boost_on_o}, 2'h0);
        for (int p = 0; p < 4; p++) begin
            @(posedge clk_i) phone_type_i <= 2'(p);
            wt(2);
            chk(dpdm_level_o, (p == 3) ? 0 : p);
        end
        @(posedge clk_i) {micro_adapter_i, die_regulate_i} <= 2'h3;
        wt(3);
        chk({micro_path_o, chg_enable_o, chg_thermal_reduce_o, small_mode_o, try_src_o, power_off_o}, 6'h3a);
        test_done;
    end
endmodule
